// ### common/upb_pkg.sv
// constants, field layout and state type for the upper pin bank block
// assumes a single 125 MHz clock and a synchronous active-high reset
package upb_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int DEB_TIME_US = 10000;
  localparam int DEB_TICKS_DEF = DEB_TIME_US / TICK_US;
  localparam int WAIT_TIME_MS = 500;
  localparam int WAIT_TICKS_DEF = WAIT_TIME_MS * 1000 / TICK_US;
  localparam int TICK_W = 7;
  localparam int DCNT_W = 14;
  localparam int WCNT_W = 19;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_PAIR_8_9 = 6'h19;
  localparam logic [5:0] IDX_PAIR_10_11 = 6'h1a;
  localparam logic [5:0] IDX_PAIR_12_13 = 6'h1b;
  localparam logic [5:0] IDX_PAIR_14_15 = 6'h1c;
  localparam logic [5:0] IDX_PIN_STATUS = 6'h1d;
  localparam logic [2:0] SEL_STATUS = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;
  localparam logic [7:0] CFG_RESET = 8'h11;

  // ----------------------------------------------------------------
  // field layout inside one pair register
  // ----------------------------------------------------------------
  localparam int HALF_W = 4;
  localparam int FSEL_LSB = 0;
  localparam int POL_BIT = 2;
  localparam int MODE_BIT = 3;
  localparam logic [1:0] FSEL_ALT = 2'h0;
  localparam logic [1:0] FSEL_IN = 2'h1;
  localparam logic [1:0] FSEL_OD = 2'h2;
  localparam logic [1:0] FSEL_PP = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0][7:0] cfg;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] stable;
    logic [7:0][DCNT_W-1:0] dcnt;
    logic [7:0] act_q;
    logic [2:0] fl_s;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [WCNT_W-1:0] wcnt;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] in_level;
    logic sysdom_en;
    logic pdom_en;
    logic pdom2_en;
    logic acc_det;
    logic reg9_en;
    logic sda_in;
    logic scl_in;
    logic wake;
    logic wait_to;
    logic awready;
    logic aw_held;
    logic [7:0] aw_addr;
    logic wready;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } upb_state_s;

endpackage

// ### test/upb_gpio_bench.sv
// self-checking bench for the upper pin bank
// assumes the pin world model and the checker are compiled first
`timescale 1ns/1ps

module upb_gpio_bench
  import upb_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pin_in, pin_out, pin_oe, general_input, ext_val = 8'hff, ext_en = 8'h00;
  logic rtc_blink = 1'b0, pwm_level = 1'b0, feedback_pin_one = 1'b0, supply_fault_out_n = 1'b1;
  logic two_wire_data_low = 1'b0, fast_two_wire_access = 1'b0, wait_step_active = 1'b0;
  logic accessory_float_flag = 1'b1;
  logic system_domain_enable, power_domain_enable, second_power_domain_enable;
  logic accessory_detect, regulator_nine_enable, wake_event, wait_timeout;
  logic two_wire_data_in, two_wire_clk_in;
  logic [33:0] exp_q[$];
  int error_cnt = 0, checked = 0, cyc = 0, wakes = 0;

  upb_gpio #(.DEB_TICKS(3), .WAIT_TICKS(5)) upb_gpio_i (.*);
  upb_pin_world upb_pin_world_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));

  initial begin
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_q.push_back({r, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // answers are matched against the oldest note; sources wander slowly
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (wake_event === 1'b1) wakes++;
    if (cyc % 8 == 0) begin
      {rtc_blink, pwm_level, feedback_pin_one, supply_fault_out_n} <= 4'($urandom);
    end
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d;
    int n;
    void'($urandom(32'hc046));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int j = 0; j < 4; j++) rd(8'h64 + 8'(4 * j), CFG_RESET, RESP_OKAY);
    rd(8'h74, 8'h00, RESP_OKAY);
    rd(8'h78, 8'h00, RESP_SLVERR);
    wr(8'h74, 8'hff, RESP_SLVERR);
    wr(8'h65, 8'h33, RESP_SLVERR);
    rd(8'h64, CFG_RESET, RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      d = (8'($urandom) & 8'hcc) | {2'h0, 2'(i >> 2), 2'h0, 2'(i)};
      for (int j = 0; j < 4; j++) begin
        wr(8'h64 + 8'(4 * j), d, RESP_OKAY);
        rd(8'h64 + 8'(4 * j), d, RESP_OKAY);
      end
      repeat (4) @(posedge clk);
    end
    // active level follows polarity
    wr(8'h64, 8'h51, RESP_OKAY);
    for (int j = 1; j < 4; j++) wr(8'h64 + 8'(4 * j), CFG_RESET, RESP_OKAY);
    ext_en <= 8'hff;
    ext_val <= 8'hfe;
    repeat (6) @(posedge clk);
    rd(8'h74, 8'h03, RESP_OKAY);
    ext_val <= 8'hfd;
    repeat (6) @(posedge clk);
    rd(8'h74, 8'h00, RESP_OKAY);
    // debounced wake, then a short glitch that must be ignored
    wr(8'h64, 8'hd1, RESP_OKAY);
    repeat (1000) @(posedge clk);
    n = wakes;
    ext_val <= 8'hff;
    repeat (1000) @(posedge clk);
    chk(34'(wakes), 34'(n + 1));
    rd(8'h74, 8'h02, RESP_OKAY);
    ext_val <= 8'hfd;
    repeat (20) @(posedge clk);
    ext_val <= 8'hff;
    repeat (1000) @(posedge clk);
    chk(34'(wakes), 34'(n + 1));
    // port access wakes only in mode 1
    for (int m = 1; m >= 0; m--) begin
      wr(8'h70, 8'(m << 3), RESP_OKAY);
      // let the checker's settle count run out so it judges the pulse
      repeat (4) @(posedge clk);
      n = wakes;
      fast_two_wire_access <= 1'b1;
      @(posedge clk);
      fast_two_wire_access <= 1'b0;
      repeat (4) @(posedge clk);
      chk(34'(wakes), 34'(n + m));
    end
    ext_val <= 8'hbf;
    repeat (5) @(posedge clk);
    chk(34'(two_wire_data_in), 34'h0);
    // regulator control by raw input, dropped in mode 1; interrupt mask lives outside
    ext_val <= 8'hef;
    wr(8'h6c, 8'h11, RESP_OKAY);
    repeat (5) @(posedge clk);
    chk(34'(regulator_nine_enable), 34'h1);
    wr(8'h6c, 8'h19, RESP_OKAY);
    repeat (5) @(posedge clk);
    chk(34'(regulator_nine_enable), 34'h0);
    // wait-step timeout and system enable
    wr(8'h68, 8'h18, RESP_OKAY);
    wr(8'h64, 8'h1c, RESP_OKAY);
    ext_val <= 8'hff;
    wait_step_active <= 1'b1;
    repeat (1000) @(posedge clk);
    chk({32'h0, second_power_domain_enable, wait_timeout}, 34'h1);
    chk(34'(system_domain_enable), 34'h1);
    wait_step_active <= 1'b0;
    wr(8'h64, 8'h14, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(34'(system_domain_enable), 34'h0);
    // power enables, accessory detect and its float wake, two-wire clock
    wr(8'h64, 8'h44, RESP_OKAY);
    wr(8'h68, 8'h80, RESP_OKAY);
    ext_val <= 8'h73;
    repeat (600) @(posedge clk);
    chk(34'(power_domain_enable), 34'h1);
    chk(34'(second_power_domain_enable), 34'h1);
    chk(34'(accessory_detect), 34'h1);
    chk(34'(two_wire_clk_in), 34'h0);
    chk(34'(general_input), 34'h8f);
    n = wakes;
    accessory_float_flag <= 1'b0;
    repeat (8) @(posedge clk);
    chk(34'(wakes), 34'(n + 1));
    report_and_stop();
  end
endmodule

bind upb_gpio upb_gpio_checker upb_gpio_checker_i (.*);

// ### test/upb_gpio_checker.sv
// assertions for the upper pin bank, seen from its ports only
// assumes one bus write at a time; keeps a shadow of the pair registers
`timescale 1ns/1ps

module upb_gpio_checker
  import upb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // pins and sources
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic rtc_blink,
  input wire logic pwm_level,
  input wire logic feedback_pin_one,
  input wire logic supply_fault_out_n,
  input wire logic fast_two_wire_access,
  // results
  input wire logic wake_event,
  input wire logic system_domain_enable,
  input wire logic regulator_nine_enable
);
  logic [3:0][7:0] sh;
  logic [7:0] wa, wd;
  logic ws;
  logic [1:0] q;
  wire ok = q == 2'h3;
  wire [5:0] wi = wa[7:2];

  // ------------------------------------------------------------
  // shadow registers
  // ------------------------------------------------------------
  // pin and result outputs are judged only three settled cycles after a write lands
  always_ff @(posedge clk) begin
    if (rst) begin
      sh <= {4{CFG_RESET}};
      q <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
      if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY && ws &&
          wi >= IDX_PAIR_8_9 && wi <= IDX_PAIR_14_15) sh[2'(wi - IDX_PAIR_8_9)] <= wd;
      if ((s_axi_awvalid && s_axi_awready) || s_axi_bvalid) q <= 2'h0;
      else if (!ok) q <= q + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_answer;
    s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
  endsequence
  read_answer_a: assert property (rd_take |=> rd_answer)
    else $error("read not answered a cycle after its address");
  pin8_pushpull_a: assert property (
    ok && sh[0][1:0] == FSEL_PP |-> pin_oe[0] && pin_out[0] == sh[0][3])
    else $error("pin 8 push-pull level wrong");
  pin9_drain_a: assert property (
    ok && sh[0][5:4] == FSEL_OD |-> !pin_out[1] && pin_oe[1] == !sh[0][7])
    else $error("pin 9 open-drain drive wrong");
  pin10_blink_a: assert property (
    ok && sh[1][1:0] == FSEL_PP && sh[1][2] |-> pin_oe[2] && pin_out[2] == $past(rtc_blink))
    else $error("pin 10 blink level wrong");
  pin13_pushpull_a: assert property (
    ok && sh[2][5:4] == FSEL_PP |-> pin_oe[5] && pin_out[5] == sh[2][7])
    else $error("pin 13 push-pull level wrong");
  pin15_pwm_a: assert property (
    ok && sh[3][5:4] == FSEL_OD |-> !pin_out[7] && pin_oe[7] == !(sh[3][7] && $past(pwm_level)))
    else $error("pin 15 pwm drive wrong");
  port_wake_a: assert property (
    ok && sh[3][1:0] == FSEL_ALT && sh[3][3] && fast_two_wire_access |=> wake_event)
    else $error("port access gave no wake");
  reg_nine_off_a: assert property (
    ok && sh[2][1:0] == FSEL_IN && sh[2][3] |-> !regulator_nine_enable)
    else $error("regulator enable active in mode 1");
  sysdom_off_a: assert property (
    ok && (sh[0][1:0] != FSEL_ALT || !sh[0][3]) |-> !system_domain_enable)
    else $error("system enable outside its function");
  pin11_blink_a: assert property (
    ok && sh[1][5:4] == FSEL_OD && sh[1][6] |-> !pin_out[3] && pin_oe[3] == !$past(rtc_blink))
    else $error("pin 11 blink drive wrong");
  pin12_feedback_a: assert property (
    ok && sh[2][1:0] == FSEL_ALT |-> pin_oe[4] && pin_out[4] == $past(feedback_pin_one))
    else $error("pin 12 feedback drive wrong");
  pin13_fault_a: assert property (
    ok && sh[2][5:4] == FSEL_ALT |-> !pin_out[5] && pin_oe[5] == !$past(supply_fault_out_n))
    else $error("pin 13 fault drive wrong");
endmodule

// ### test/upb_pin_world.sv
// board side of pins 8 to 15: pull-ups and outside drivers
// assumes oe high means the bank drives the pin
`timescale 1ns/1ps

module upb_pin_world (
  // from the bank
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // outside drivers
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // resolved level
  output logic [7:0] pin_in
);
  // an undriven pin floats up; two drivers fight as a wired and
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = ext_en[i] ? ext_val[i] : 1'b1;
      if (pin_oe[i]) pin_in[i] = pin_in[i] & pin_out[i];
    end
  end
endmodule

// ### verilog/upb_gpio.sv
// upper pin bank (pins 8 to 15): function select, polarity, mode,
// debounce, wake-up events and alternate functions, AXI4-Lite registers
// assumes pins and the float flag arrive asynchronously; all other inputs share clk
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module upb_gpio
  import upb_pkg::*;
#(
  parameter int DEB_TICKS = DEB_TICKS_DEF,
  parameter int WAIT_TICKS = WAIT_TICKS_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // pins 8 to 15, index 0 is pin 8
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // sources inside the device
  input wire logic rtc_blink,
  input wire logic pwm_level,
  input wire logic feedback_pin_one,
  input wire logic supply_fault_out_n,
  input wire logic two_wire_data_low,
  input wire logic fast_two_wire_access,
  input wire logic wait_step_active,
  input wire logic accessory_float_flag,
  // to the power manager
  output logic system_domain_enable,
  output logic power_domain_enable,
  output logic second_power_domain_enable,
  output logic accessory_detect,
  output logic regulator_nine_enable,
  output logic wake_event,
  output logic wait_timeout,
  output logic [7:0] general_input,
  // to the two-wire port
  output logic two_wire_data_in,
  output logic two_wire_clk_in
);

  // ----------------------------------------------------------------
  // constants and decode
  // ----------------------------------------------------------------
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [DCNT_W-1:0] DEB_LAST = DCNT_W'(DEB_TICKS - 1);
  localparam logic [WCNT_W-1:0] WAIT_LAST = WCNT_W'(WAIT_TICKS - 1);

  // byte address to register slot; misaligned or unknown gives none
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[7:2])
        IDX_PAIR_8_9: s = 3'h0;
        IDX_PAIR_10_11: s = 3'h1;
        IDX_PAIR_12_13: s = 3'h2;
        IDX_PAIR_14_15: s = 3'h3;
        IDX_PIN_STATUS: s = SEL_STATUS;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction

  upb_state_s r;
  upb_state_s next_r;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] fsel_alt;
    logic [7:0] mode;
    logic [1:0] f;
    logic pol;
    logic md;
    logic raw_act;
    logic deb_act;
    logic eff;
    logic lvl;
    logic wake_en;
    logic fl_fall;
    logic [2:0] ws;
    logic [2:0] rs;
    fsel_alt = 8'h00;
    mode = 8'h00;
    f = 2'h0;
    pol = 1'b0;
    md = 1'b0;
    raw_act = 1'b0;
    deb_act = 1'b0;
    eff = 1'b0;
    lvl = 1'b0;
    wake_en = 1'b0;
    fl_fall = 1'b0;
    ws = SEL_NONE;
    rs = SEL_NONE;
    next_r = r;

    // 1 us enable for debounce and wait counting
    next_r.tick = 1'b0;
    if (r.tick_cnt == TICK_LAST) begin
      next_r.tick_cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 1'b1;
    end

    // pin and float synchronisers; fl_s[2] is the previous synced value
    next_r.s1 = pin_in;
    next_r.s2 = r.s1;
    next_r.fl_s = {r.fl_s[1:0], accessory_float_flag};
    fl_fall = r.fl_s[2] & ~r.fl_s[1];

    next_r.wake = 1'b0;
    for (int i = 0; i < 8; i++) begin
      f = r.cfg[i/2][HALF_W*(i%2)+FSEL_LSB +: 2];
      pol = r.cfg[i/2][HALF_W*(i%2)+POL_BIT];
      md = r.cfg[i/2][HALF_W*(i%2)+MODE_BIT];
      fsel_alt[i] = (f == FSEL_ALT);
      mode[i] = md;

      // debounce: a level must hold for DEB_TICKS ticks to be taken
      if (r.s2[i] == r.stable[i]) begin
        next_r.dcnt[i] = '0;
      end else if (r.tick) begin
        if (r.dcnt[i] == DEB_LAST) begin
          next_r.stable[i] = r.s2[i];
          next_r.dcnt[i] = '0;
        end else begin
          next_r.dcnt[i] = r.dcnt[i] + 1'b1;
        end
      end

      // polarity maps pin level to active level
      raw_act = pol ? r.s2[i] : ~r.s2[i];
      deb_act = pol ? r.stable[i] : ~r.stable[i];
      eff = md ? deb_act : raw_act;
      next_r.in_level[i] = eff;
      next_r.act_q[i] = eff;

      // pin 12 input only steers the regulator, it raises no wake
      wake_en = md & ((f == FSEL_IN && i != 4) ||
                      (f == FSEL_ALT && i < 3));
      if (wake_en && eff && !r.act_q[i]) begin
        next_r.wake = 1'b1;
      end

      // output level from mode bit, blink or pwm where offered
      lvl = md;
      if ((i == 2 || i == 3) && pol) begin
        lvl = rtc_blink;
      end
      if (i >= 6 && f == FSEL_OD) begin
        lvl = md & pwm_level;
      end

      case (f)
        FSEL_OD: begin
          next_r.pin_out[i] = 1'b0;
          next_r.pin_oe[i] = ~lvl;
        end
        FSEL_PP: begin
          next_r.pin_out[i] = lvl;
          next_r.pin_oe[i] = 1'b1;
        end
        FSEL_IN: begin
          next_r.pin_out[i] = 1'b0;
          next_r.pin_oe[i] = 1'b0;
        end
        default: begin
          next_r.pin_out[i] = 1'b0;
          next_r.pin_oe[i] = 1'b0;
          if (i == 4) begin
            next_r.pin_out[i] = feedback_pin_one;
            next_r.pin_oe[i] = 1'b1;
          end else if (i == 5) begin
            next_r.pin_oe[i] = ~supply_fault_out_n;
          end else if (i == 6) begin
            next_r.pin_oe[i] = two_wire_data_low;
          end
        end
      endcase
    end

    // ----------------------------------------------------------------
    // alternate input functions
    // ----------------------------------------------------------------
    next_r.sysdom_en = fsel_alt[0] & mode[0] & next_r.in_level[0];
    next_r.pdom_en = fsel_alt[1] & next_r.in_level[1];
    next_r.pdom2_en = fsel_alt[2] & next_r.in_level[2];
    next_r.acc_det = fsel_alt[3] & next_r.in_level[3];
    // mode 0 leaves the raw level, so the enable follows it undebounced
    next_r.reg9_en = (r.cfg[2][1:0] == FSEL_IN) & ~mode[4] &
                     next_r.in_level[4];
    if (fsel_alt[3] && mode[3] && fl_fall) begin
      next_r.wake = 1'b1;
    end

    // pin 15 follows pin 14 into the two-wire role
    next_r.sda_in = fsel_alt[6] ? r.s2[6] : 1'b1;
    next_r.scl_in = fsel_alt[6] ? r.s2[7] : 1'b1;
    if (fsel_alt[6] && mode[6] && fast_two_wire_access) begin
      next_r.wake = 1'b1;
    end

    // wait step timeout; held until the wait step ends
    if (fsel_alt[2] && mode[2] && wait_step_active) begin
      if (r.tick && !r.wait_to) begin
        if (r.wcnt == WAIT_LAST) begin
          next_r.wait_to = 1'b1;
        end else begin
          next_r.wcnt = r.wcnt + 1'b1;
        end
      end
    end else begin
      next_r.wcnt = '0;
      next_r.wait_to = 1'b0;
    end

    // ----------------------------------------------------------------
    // axi4-lite write
    // ----------------------------------------------------------------
    if (r.awready && s_axi_awvalid) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (r.wready && s_axi_wvalid) begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata[7:0];
      next_r.w_strb = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      ws = reg_sel(r.aw_addr);
      next_r.bresp = RESP_SLVERR;
      if (ws < SEL_STATUS) begin
        next_r.bresp = RESP_OKAY;
        if (r.w_strb) begin
          next_r.cfg[ws[1:0]] = r.w_data;
        end
      end
      next_r.bvalid = 1'b1;
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
    end
    next_r.awready = ~next_r.aw_held & ~next_r.bvalid;
    next_r.wready = ~next_r.w_held & ~next_r.bvalid;

    // ----------------------------------------------------------------
    // axi4-lite read
    // ----------------------------------------------------------------
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (r.arready && s_axi_arvalid) begin
      rs = reg_sel(s_axi_araddr);
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      if (rs < SEL_STATUS) begin
        next_r.rdata = r.cfg[rs[1:0]];
      end else if (rs == SEL_STATUS) begin
        next_r.rdata = r.in_level;
      end else begin
        next_r.rdata = 8'h00;
        next_r.rresp = RESP_SLVERR;
      end
    end
    next_r.arready = ~next_r.rvalid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.cfg <= {4{CFG_RESET}};
      r.s1 <= 8'hff;
      r.s2 <= 8'hff;
      r.stable <= 8'hff;
      r.fl_s <= 3'h0;
      r.sda_in <= 1'b1;
      r.scl_in <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = {24'h000000, r.rdata};
  assign s_axi_rresp = r.rresp;
  assign pin_out = r.pin_out;
  assign pin_oe = r.pin_oe;
  assign system_domain_enable = r.sysdom_en;
  assign power_domain_enable = r.pdom_en;
  assign second_power_domain_enable = r.pdom2_en;
  assign accessory_detect = r.acc_det;
  assign regulator_nine_enable = r.reg9_en;
  assign wake_event = r.wake;
  assign wait_timeout = r.wait_to;
  assign general_input = r.in_level;
  assign two_wire_data_in = r.sda_in;
  assign two_wire_clk_in = r.scl_in;

endmodule
